// *** hw/acc_pkg.sv ***
package acc_pkg;

  // ****************************************************************
  // Register map and control fields
  // ****************************************************************
  localparam logic [7:0] CTRL_ADDR       = 8'he8;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam int         BIT_ENABLE      = 7;
  localparam int         BIT_TRACK_MODE  = 6;
  localparam int         BIT_DONE        = 5;
  localparam int         BIT_BUSY        = 4;
  localparam int         BIT_WINDOW      = 3;
  localparam int         SRC_MSB         = 2;
  localparam int         SRC_LSB         = 0;

  // ****************************************************************
  // Start-of-conversion source codes
  // ****************************************************************
  localparam logic [2:0] SRC_SOFTWARE    = 3'h0;
  localparam logic [2:0] SRC_TIMER_ZERO  = 3'h1;
  localparam logic [2:0] SRC_TIMER_A     = 3'h2;
  localparam logic [2:0] SRC_TIMER_B     = 3'h3;
  localparam logic [2:0] SRC_EXT_EDGE    = 3'h4;
  localparam logic [2:0] SRC_TIMER_C     = 3'h5;

  // ****************************************************************
  // Converter geometry and timing
  // ****************************************************************
  localparam int         RESULT_W        = 10;
  localparam int         DIV_W           = 5;
  localparam logic [1:0] DELAY_TICKS     = 2'h3;
  localparam logic [3:0] TOP_BIT         = 4'h9;
  localparam logic [DIV_W-1:0] DIV_RESET = 5'h00;

  // Special function register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
    logic       bit_wr;
    logic [2:0] bit_sel;
    logic       bit_val;
  } acc_sfr_req_t;

  // Overflow pulses of the on-chip timers
  typedef struct packed {
    logic timer_zero;
    logic timer_a;
    logic timer_b;
    logic timer_c;
  } acc_timer_ovf_t;

  // Window limits, right-justified words
  typedef struct packed {
    logic [RESULT_W-1:0] greater;
    logic [RESULT_W-1:0] less;
  } acc_window_t;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_DELAY,
    ACC_CONV
  } acc_state_t;

endpackage

// *** hw/acc_ctrl.sv ***
`timescale 1ns/1ps
// Overview of operation
// [R1] Enable bit low gives shutdown; high lets the converter accept starts.
// [R2] Normal track mode tracks continuously while enabled, except mid-conversion.
// [R3] Normal track mode converts at once on the start event.
// [R4] Delayed track mode tracks three extra conversion clocks before converting.
// [R5] Completion flag is set whenever a conversion finishes.
// [R6] Completion flag holds until software clears it.
// [R7] Busy bit reads one during a conversion, zero otherwise; the code also reads one through the ACC_DELAY tracking wait.
// [R8] Writing one to busy starts a conversion only with source 000; zero ignored.
// [R9] Window flag is set when a window match occurs; sticky until cleared.
// [R10] Source 001 starts on timer zero overflow.
// [R11] Sources 010, 011, 101 use other timers; 100 uses external rising edge.
// [R12] Control register sits at address 0xE8 with single-bit set and clear.
// [R13] Software avoids reserved source codes 110 and 111.
// [R14] Busy clears in the cycle the done flag sets and result updates.
// [R15] Window detector checks each result against limits, inside or outside.
// [R16] Conversion clock period is divider field plus one system clocks.
module acc_ctrl (
  input  wire logic                         mclk,
  input  wire logic                         rst_b,
  input  wire acc_pkg::acc_sfr_req_t        sfr_req,
  output      logic [7:0]                   sfr_rdata,
  input  wire acc_pkg::acc_timer_ovf_t      timer_ovf,
  input  wire logic                         ext_start_pin,
  input  wire logic [acc_pkg::DIV_W-1:0]    conversion_clock_divider,
  input  wire acc_pkg::acc_window_t         window_limits,
  input  wire logic                         sar_cmp,
  output      logic [acc_pkg::RESULT_W-1:0] dac_code,
  output      logic                         conv_power_on,
  output      logic                         conv_track,
  output      logic [acc_pkg::RESULT_W-1:0] result,
  output      logic                         result_strobe
);
  import acc_pkg::*;

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Inside window when less > greater, otherwise outside window
  function automatic logic window_hit(input logic [RESULT_W-1:0] word,
                                      input acc_window_t lim);
    logic in_win;
    in_win = (word > lim.greater) && (word < lim.less);
    if (lim.less > lim.greater) begin
      window_hit = in_win;
    end else begin
      window_hit = (word < lim.less) || (word > lim.greater);
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic                converter_enable_bit;
  logic                track_mode_select;
  logic                conversion_done_flag;
  logic                window_match_flag;
  logic [2:0]          start_source_select;
  acc_state_t          state;
  logic [DIV_W-1:0]    div_cnt;
  logic [1:0]          delay_cnt;
  logic [3:0]          bit_pos;
  logic                pin_meta;
  logic                pin_sync;
  logic                pin_last;

  logic                next_converter_enable_bit;
  logic                next_track_mode_select;
  logic                next_conversion_done_flag;
  logic                next_window_match_flag;
  logic [2:0]          next_start_source_select;
  acc_state_t          next_state;
  logic [DIV_W-1:0]    next_div_cnt;
  logic [1:0]          next_delay_cnt;
  logic [3:0]          next_bit_pos;
  logic [RESULT_W-1:0] next_dac_code;
  logic [RESULT_W-1:0] next_result;
  logic                next_result_strobe;
  logic [7:0]          next_sfr_rdata;

  logic                ctrl_hit;
  logic [7:0]          wr_mask;
  logic [7:0]          wr_value;
  logic [7:0]          ctrl_byte;
  logic                sw_start;
  logic                trigger;
  logic                start_ev;
  logic                sar_tick;
  logic                conv_finish;
  logic [RESULT_W-1:0] final_code;

  // ****************************************************************
  // External start pin synchroniser
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_last <= 1'b0;
    end else begin
      pin_meta <= ext_start_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // ****************************************************************
  // Register access decode
  // ****************************************************************

  // Byte writes touch all bits, bit writes touch one
  always_comb begin
    ctrl_hit = (sfr_req.addr == CTRL_ADDR);
    wr_mask  = 8'h00;
    wr_value = sfr_req.wdata;
    if (ctrl_hit && sfr_req.wr) begin
      wr_mask = 8'hff;
    end else if (ctrl_hit && sfr_req.bit_wr) begin // [R12]
      wr_mask  = 8'h01 << sfr_req.bit_sel;
      wr_value = {8{sfr_req.bit_val}};
    end
  end

  // Control byte as software sees it
  always_comb begin
    ctrl_byte = CTRL_RESET;
    ctrl_byte[BIT_ENABLE]       = converter_enable_bit;
    ctrl_byte[BIT_TRACK_MODE]   = track_mode_select;
    ctrl_byte[BIT_DONE]         = conversion_done_flag;
    ctrl_byte[BIT_BUSY]         = (state != ACC_IDLE); // [R7]
    ctrl_byte[BIT_WINDOW]       = window_match_flag;
    ctrl_byte[SRC_MSB:SRC_LSB]  = start_source_select;
  end

  // ****************************************************************
  // Start-of-conversion selection
  // ****************************************************************
  always_comb begin
    sw_start = wr_mask[BIT_BUSY] && wr_value[BIT_BUSY]; // [R8]
    unique case (start_source_select)
      SRC_SOFTWARE:   trigger = sw_start;                 // [R8]
      SRC_TIMER_ZERO: trigger = timer_ovf.timer_zero;     // [R10]
      SRC_TIMER_A:    trigger = timer_ovf.timer_a;        // [R11]
      SRC_TIMER_B:    trigger = timer_ovf.timer_b;        // [R11]
      SRC_EXT_EDGE:   trigger = pin_sync && !pin_last;    // [R11]
      SRC_TIMER_C:    trigger = timer_ovf.timer_c;        // [R11]
      default:        trigger = 1'b0;                     // [R13]
    endcase
    start_ev = trigger && converter_enable_bit && (state == ACC_IDLE); // [R1]
  end

  // ****************************************************************
  // Conversion clock divider
  // ****************************************************************

  // Restarts on each start so every period is whole
  always_comb begin
    sar_tick     = (div_cnt == conversion_clock_divider); // [R16]
    next_div_cnt = div_cnt + 5'h01;
    if (!converter_enable_bit || start_ev || sar_tick) begin
      next_div_cnt = DIV_RESET;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= DIV_RESET;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ****************************************************************
  // Sequencer and successive approximation
  // ****************************************************************
  always_comb begin
    next_state         = state;
    next_delay_cnt     = delay_cnt;
    next_bit_pos       = bit_pos;
    next_dac_code      = dac_code;
    next_result        = result;
    next_result_strobe = 1'b0;
    conv_finish        = 1'b0;
    final_code         = dac_code;
    final_code[bit_pos] = sar_cmp;
    unique case (state)
      ACC_IDLE: begin
        if (start_ev && track_mode_select) begin
          next_state     = ACC_DELAY; // [R4]
          next_delay_cnt = 2'h1;
        end else if (start_ev) begin
          next_state    = ACC_CONV; // [R3]
          next_bit_pos  = TOP_BIT;
          next_dac_code = 10'h200;
        end
      end
      ACC_DELAY: begin
        if (sar_tick && delay_cnt == DELAY_TICKS) begin
          next_state    = ACC_CONV; // [R4]
          next_bit_pos  = TOP_BIT;
          next_dac_code = 10'h200;
        end else if (sar_tick) begin
          next_delay_cnt = delay_cnt + 2'h1;
        end
      end
      ACC_CONV: begin
        if (sar_tick && bit_pos == 4'h0) begin
          next_state         = ACC_IDLE; // [R14]
          next_result        = final_code;
          next_result_strobe = 1'b1;
          next_dac_code      = final_code;
          conv_finish        = 1'b1;
        end else if (sar_tick) begin
          next_bit_pos  = bit_pos - 4'h1;
          next_dac_code = final_code | (10'h001 << (bit_pos - 4'h1));
        end
      end
    endcase
    if (!converter_enable_bit) begin
      next_state = ACC_IDLE; // [R1]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state         <= ACC_IDLE;
      delay_cnt     <= 2'h0;
      bit_pos       <= 4'h0;
      dac_code      <= 10'h000;
      result        <= 10'h000;
      result_strobe <= 1'b0;
    end else begin
      state         <= next_state;
      delay_cnt     <= next_delay_cnt;
      bit_pos       <= next_bit_pos;
      dac_code      <= next_dac_code;
      result        <= next_result;
      result_strobe <= next_result_strobe;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************

  // Hardware set wins over a software clear
  always_comb begin
    next_converter_enable_bit = converter_enable_bit;
    next_track_mode_select    = track_mode_select;
    next_start_source_select  = start_source_select;
    next_conversion_done_flag = conversion_done_flag;
    next_window_match_flag    = window_match_flag;
    if (wr_mask[BIT_ENABLE]) begin
      next_converter_enable_bit = wr_value[BIT_ENABLE];
    end
    if (wr_mask[BIT_TRACK_MODE]) begin
      next_track_mode_select = wr_value[BIT_TRACK_MODE];
    end
    for (int i = SRC_LSB; i <= SRC_MSB; i++) begin
      if (wr_mask[i]) begin
        next_start_source_select[i] = wr_value[i];
      end
    end
    if (wr_mask[BIT_DONE]) begin
      next_conversion_done_flag = wr_value[BIT_DONE]; // [R6]
    end
    if (wr_mask[BIT_WINDOW]) begin
      next_window_match_flag = wr_value[BIT_WINDOW];
    end
    if (conv_finish) begin
      next_conversion_done_flag = 1'b1; // [R5] [R14]
    end
    if (conv_finish && window_hit(final_code, window_limits)) begin
      next_window_match_flag = 1'b1; // [R9] [R15]
    end
    next_sfr_rdata = 8'h00;
    if (ctrl_hit && sfr_req.rd) begin
      next_sfr_rdata = ctrl_byte;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      converter_enable_bit <= CTRL_RESET[BIT_ENABLE];
      track_mode_select    <= CTRL_RESET[BIT_TRACK_MODE];
      conversion_done_flag <= CTRL_RESET[BIT_DONE];
      window_match_flag    <= CTRL_RESET[BIT_WINDOW];
      start_source_select  <= CTRL_RESET[SRC_MSB:SRC_LSB];
      sfr_rdata            <= 8'h00;
    end else begin
      converter_enable_bit <= next_converter_enable_bit;
      track_mode_select    <= next_track_mode_select;
      conversion_done_flag <= next_conversion_done_flag;
      window_match_flag    <= next_window_match_flag;
      start_source_select  <= next_start_source_select;
      sfr_rdata            <= next_sfr_rdata;
    end
  end

  // ****************************************************************
  // Analog control outputs
  // ****************************************************************
  assign conv_power_on = converter_enable_bit;                         // [R1]
  assign conv_track    = converter_enable_bit && (state != ACC_CONV);  // [R2]

endmodule

// *** sim/acc_ctrl_checker.sv ***
`timescale 1ns/1ps
module acc_ctrl_checker (
  input wire logic                         mclk,
  input wire logic                         rst_b,
  input wire acc_pkg::acc_sfr_req_t        sfr_req,
  input wire logic [7:0]                   sfr_rdata,
  input wire acc_pkg::acc_timer_ovf_t      timer_ovf,
  input wire logic                         ext_start_pin,
  input wire logic [acc_pkg::DIV_W-1:0]    conversion_clock_divider,
  input wire acc_pkg::acc_window_t         window_limits,
  input wire logic                         sar_cmp,
  input wire logic [acc_pkg::RESULT_W-1:0] dac_code,
  input wire logic                         conv_power_on,
  input wire logic                         conv_track,
  input wire logic [acc_pkg::RESULT_W-1:0] result,
  input wire logic                         result_strobe
);
  import acc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ****************************************************************
  // Control writes taken while tracking, in the idle or delay state
  // ****************************************************************
  logic       sw_wr;
  logic       go;
  logic [2:0] src_m;
  logic       tm_m;
  // Shadow of source and track mode as they stand before each write
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      src_m <= 3'h0;
      tm_m  <= 1'b0;
    end else if (sfr_req.wr && sfr_req.addr == CTRL_ADDR) begin
      src_m <= sfr_req.wdata[SRC_MSB:SRC_LSB];
      tm_m  <= sfr_req.wdata[BIT_TRACK_MODE];
    end else if (sfr_req.bit_wr && sfr_req.addr == CTRL_ADDR) begin
      if (sfr_req.bit_sel == 3'(BIT_TRACK_MODE)) begin
        tm_m <= sfr_req.bit_val;
      end else if (sfr_req.bit_sel <= 3'(SRC_MSB)) begin
        src_m[sfr_req.bit_sel[1:0]] <= sfr_req.bit_val;
      end
    end
  end
  assign sw_wr = sfr_req.wr && sfr_req.addr == CTRL_ADDR && conv_track && timer_ovf == '0;
  // Busy write with the stored source at software start
  assign go    = sw_wr && sfr_req.wdata[7] && sfr_req.wdata[4] && src_m == SRC_SOFTWARE;
  property p_off_quiet; !conv_power_on |-> !conv_track; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("tracking while disabled");
  property p_rd_power;
    sfr_req.rd && sfr_req.addr == CTRL_ADDR |=> sfr_rdata[7] == $past(conv_power_on);
  endproperty
  a_rd_power: assert property (p_rd_power) else $error("enable bit readback wrong");
  property p_sw_start;
    go && !tm_m |=> !conv_track;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software start ignored");
  property p_no_start;
    sw_wr && sfr_req.wdata[7] && !go |=> conv_track;
  endproperty
  a_no_start: assert property (p_no_start) else $error("start without cause");
  property p_delay;
    go && tm_m |=> conv_track [*3] ##[1:400] !conv_track;
  endproperty
  a_delay: assert property (p_delay) else $error("delayed tracking wrong");
  property p_msb_first; $fell(conv_track) && conv_power_on |-> dac_code == 10'h200; endproperty
  a_msb_first: assert property (p_msb_first) else $error("first trial not msb");
  property p_conv_len; $fell(conv_track) && conv_power_on |-> ##[10:400] result_strobe; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_strobe_one; result_strobe |=> !result_strobe; endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("strobe too long");
  property p_end_track; result_strobe |-> conv_track && conv_power_on; endproperty
  a_end_track: assert property (p_end_track) else $error("no tracking at end");
  property p_rd_miss; sfr_req.rd && sfr_req.addr != CTRL_ADDR |=> sfr_rdata == 8'h00; endproperty
  a_rd_miss: assert property (p_rd_miss) else $error("unmapped read not zero");
  property p_rd_idle; !sfr_req.rd |=> sfr_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not released");
  c_strobe: cover property (result_strobe);
  c_delay: cover property (sfr_req.wr && sfr_req.wdata[6]);
  c_ext: cover property ($rose(ext_start_pin));
endmodule

// *** sim/acc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module acc_ctrl_tb_top;
  import acc_pkg::*;
  logic                mclk = 0, rst_b = 0, ext_start_pin = 0, sar_cmp, pwr, trk, strobe;
  acc_sfr_req_t        req = '0;
  acc_timer_ovf_t      tovf = '0;
  acc_window_t         lim = '{greater: 10'h040, less: 10'h080};
  logic [DIV_W-1:0]    div = '0;
  logic [7:0]          rdata, ctrl_m = 8'h00;
  logic [RESULT_W-1:0] dac_code, result, tgt = '0;
  int                  mismatches = 0, n_compared = 0, c0, c1;
  always #2 mclk = ~mclk;
  // Ideal comparator for a held input
  assign sar_cmp = tgt >= dac_code;
  acc_ctrl u_dut (.mclk(mclk), .rst_b(rst_b), .sfr_req(req), .sfr_rdata(rdata),
    .timer_ovf(tovf), .ext_start_pin(ext_start_pin), .conversion_clock_divider(div),
    .window_limits(lim), .sar_cmp(sar_cmp), .dac_code(dac_code), .conv_power_on(pwr),
    .conv_track(trk), .result(result), .result_strobe(strobe));
  // ****************************************************************
  // Checks and bus cycles
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Bit writes use d[2:0] as bit select and d[7] as value
  task automatic bus(input logic [7:0] a, input logic r, w, b, input logic [7:0] d);
    @(posedge mclk) req <= '{addr: a, rd: r, wr: w, wdata: d, bit_wr: b, bit_sel: d[2:0],
                             bit_val: d[7]};
    @(posedge mclk) req <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 1'b0, 1'b0, 8'h00);
    bus(a, 1'b1, 1'b0, 1'b0, 8'h00);
    #1 chk(16'(rdata), 16'(exp));
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1 chk(16'(strobe), 16'h0);
    end
  endtask
  task automatic wait_done(output int n);
    n = 0;
    while (strobe !== 1'b1) begin
      @(posedge mclk);
      #1 n++;
      if (n > 2000) begin
        mismatches++;
        $display("Error at %0t: no result strobe", $time);
        tally_and_finish();
      end
    end
  endtask
  // One conversion from the chosen source, checked against the model
  task automatic conv(input logic [2:0] src, input logic tm, input bit peek, output int n);
    tgt = 10'($urandom_range(1023));
    ctrl_m = {1'b1, tm, 3'b000, src};
    bus(CTRL_ADDR, 1'b0, 1'b1, 1'b0, ctrl_m);
    @(posedge mclk);
    if (src == 3'h0) req <= '{addr: CTRL_ADDR, wr: 1'b1, wdata: ctrl_m | 8'h10, default: '0};
    tovf <= {src == 3'h1, src == 3'h2, src == 3'h3, src == 3'h5};
    ext_start_pin <= src == 3'h4;
    @(posedge mclk);
    req <= '0;
    tovf <= '0;
    if (peek) begin
      repeat (4) @(posedge mclk);
      rd_chk(CTRL_ADDR, ctrl_m | 8'h10);
    end
    wait_done(n);
    chk(16'(result), 16'(tgt));
    if (lim.less > lim.greater ? (tgt > lim.greater && tgt < lim.less)
                               : (tgt < lim.less || tgt > lim.greater)) ctrl_m[3] = 1'b1;
    ctrl_m[5] = 1'b1;
    @(posedge mclk) ext_start_pin <= 1'b0;
    rd_chk(CTRL_ADDR, ctrl_m);
  endtask
  // A trigger that must not start anything
  task automatic refuse(input logic [2:0] src, input logic [3:0] ovf, input logic ext);
    bus(CTRL_ADDR, 1'b0, 1'b1, 1'b0, {5'h10, src});
    @(posedge mclk) tovf <= ovf;
    ext_start_pin <= ext;
    @(posedge mclk) tovf <= '0;
    quiet(30);
    @(posedge mclk) ext_start_pin <= 1'b0;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32156));
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rd_chk(CTRL_ADDR, 8'h00);
    rd_chk(8'he9, 8'h00);
    bus(CTRL_ADDR, 1'b0, 1'b1, 1'b0, 8'h80);
    #1 chk(16'({pwr, trk}), 16'h3);
    // Busy written as zero with software source: nothing starts
    bus(CTRL_ADDR, 1'b0, 1'b1, 1'b0, 8'h80);
    quiet(20);
    // Source moved off software first, then busy written as one
    bus(CTRL_ADDR, 1'b0, 1'b1, 1'b0, 8'h81);
    bus(CTRL_ADDR, 1'b0, 1'b1, 1'b0, 8'h91);
    quiet(40);
    rd_chk(CTRL_ADDR, 8'h81);
    for (int d = 0; d < 3; d++) begin
      @(posedge mclk) div <= 5'(d);
      conv(3'h0, 1'b0, 1'b0, c0);
      conv(3'h0, 1'b1, 1'b0, c1);
      chk(16'(c1 - c0), 16'(3 * (d + 1)));
      chk(16'(c0 >= 10 * (d + 1) && c0 <= 11 * (d + 1) + 1), 16'h1);
    end
    for (int s = 1; s < 6; s++) conv(3'(s), 1'b0, 1'b1, c0);
    quiet(30);
    rd_chk(CTRL_ADDR, ctrl_m);
    bus(CTRL_ADDR, 1'b0, 1'b0, 1'b1, 8'h05);
    bus(CTRL_ADDR, 1'b0, 1'b0, 1'b1, 8'h03);
    bus(CTRL_ADDR, 1'b0, 1'b0, 1'b1, 8'h86);
    rd_chk(CTRL_ADDR, (ctrl_m & 8'hd7) | 8'h40);
    @(posedge mclk) lim <= '{greater: 10'h080, less: 10'h040};
    repeat (3) conv(3'h0, 1'b0, 1'b1, c0);
    refuse(3'h1, 4'h7, 1'b1);
    refuse(3'h4, 4'hf, 1'b0);
    refuse(3'h6, 4'hf, 1'b1);
    refuse(3'h7, 4'hf, 1'b1);
    @(posedge mclk) div <= 5'h07;
    bus(CTRL_ADDR, 1'b0, 1'b1, 1'b0, 8'hc1);
    @(posedge mclk) tovf <= 4'h8;
    @(posedge mclk) tovf <= 4'h0;
    bus(CTRL_ADDR, 1'b0, 1'b1, 1'b0, 8'h00);
    #1 chk(16'({pwr, trk}), 16'h0);
    quiet(100);
    rd_chk(CTRL_ADDR, 8'h00);
    tally_and_finish();
  end
endmodule
bind acc_ctrl acc_ctrl_checker u_chk (.mclk(mclk), .rst_b(rst_b), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .timer_ovf(timer_ovf), .ext_start_pin(ext_start_pin),
  .conversion_clock_divider(conversion_clock_divider), .window_limits(window_limits),
  .sar_cmp(sar_cmp), .dac_code(dac_code), .conv_power_on(conv_power_on),
  .conv_track(conv_track), .result(result), .result_strobe(result_strobe));
